//--- hdl/fsr_pkg.sv
// shared constants and types of the flash status register logic
package fsr_pkg;

    // opcodes handled here
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_READ_STATUS  = 8'h05;

    // status byte field positions
    localparam int BIT_LOCK   = 7;
    localparam int BIT_RSVD   = 6;
    localparam int BIT_ERR    = 5;
    localparam int BIT_WPP    = 4;
    localparam int BIT_SWP_HI = 3;
    localparam int BIT_SWP_LO = 2;
    localparam int BIT_WEL    = 1;
    localparam int BIT_BUSY   = 0;

    // global protect field of the write-status data byte
    localparam int GP_HI = 5;
    localparam int GP_LO = 2;

    // software protection summary codes
    localparam logic [1:0] SWP_NONE = 2'h0;
    localparam logic [1:0] SWP_SOME = 2'h1;
    localparam logic [1:0] SWP_ALL  = 2'h3;

    // reset values
    localparam logic       LOCK_RST = 1'h0;
    localparam logic       WEL_RST  = 1'h0;
    localparam logic       ERR_RST  = 1'h0;
    localparam logic       RSVD_VAL = 1'h0;
    localparam logic [2:0] MSB_IDX  = 3'h7;

    // serial bit sequencer states
    typedef enum logic [1:0] {
        ST_OPC,
        ST_STAT,
        ST_WSR,
        ST_PASS
    } fsr_state_type;

endpackage : fsr_pkg

//--- hdl/fsr_pin_sync.sv
// two-flop synchronisers for pins entering the ref_clk domain
`timescale 1ns/10ps
`default_nettype none
module fsr_pin_sync #(
    parameter int W = 4
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] pinSync
);

    ////////////////////////////////////////////////////////////////////////
    // one two-stage chain per pin; first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_sync
            logic meta_ff;     // first stage, metastability catcher
            logic stable_ff;   // second stage, safe to use
            logic nxt_meta;
            logic nxt_stable;

            // next values, frozen while ce is low
            always_comb begin
                nxt_meta   = ce ? pinIn[i] : meta_ff;
                nxt_stable = ce ? meta_ff : stable_ff;
            end

            // registers; preset high so a deselected link looks idle
            always_ff @(posedge ref_clk or negedge nrst) begin
                if (!nrst) begin
                    meta_ff   <= 1'h1;
                    stable_ff <= 1'h1;
                end else begin
                    meta_ff   <= nxt_meta;
                    stable_ff <= nxt_stable;
                end
            end

            assign pinSync[i] = stable_ff;
        end
    endgenerate

endmodule : fsr_pin_sync
`default_nettype wire

//--- hdl/fsr_status_mux.sv
// assembles the live status byte from the block's state
`timescale 1ns/10ps
`default_nettype none
module fsr_status_mux
    import fsr_pkg::*;
#(
    parameter int NSECT = 4
) (
    input  wire logic             lockBit,
    input  wire logic             errFlag,
    input  wire logic             wpLevel,
    input  wire logic [NSECT-1:0] sectorProt,
    input  wire logic             welBit,
    input  wire logic             busyBit,
    output logic      [7:0]       statusByte
);

    logic [1:0] swpCode;   // software protection summary

    ////////////////////////////////////////////////////////////////////////
    // summary of the sector protection vector; 10 is never produced
    always_comb begin
        if (&sectorProt) begin
            swpCode = SWP_ALL;
        end else if (|sectorProt) begin
            swpCode = SWP_SOME;
        end else begin
            swpCode = SWP_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte built from live values, never from a snapshot
    always_comb begin
        statusByte                        = 8'h00;
        statusByte[BIT_LOCK]              = lockBit;
        statusByte[BIT_RSVD]              = RSVD_VAL;
        statusByte[BIT_ERR]               = errFlag;
        statusByte[BIT_WPP]               = wpLevel;
        statusByte[BIT_SWP_HI:BIT_SWP_LO] = swpCode;
        statusByte[BIT_WEL]               = welBit;
        statusByte[BIT_BUSY]              = busyBit;
    end

endmodule : fsr_status_mux
`default_nettype wire

//--- hdl/fsr_status_logic.sv
// top: serial status read/write and the flash status bits
`timescale 1ns/10ps
`default_nettype none
module fsr_status_logic
    import fsr_pkg::*;
#(
    parameter int NSECT = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             csN,
    input  wire logic             sck,
    input  wire logic             si,
    output logic                  so,
    output logic                  soOeN,
    input  wire logic             wpN,
    input  wire logic             busy,
    input  wire logic             opDone,
    input  wire logic             opFail,
    input  wire logic             weSet,
    input  wire logic             weClear,
    input  wire logic             resetCmd,
    input  wire logic [NSECT-1:0] sectorProt,
    input  wire logic             cmdGated,
    input  wire logic             cmdIsProt,
    output logic      [7:0]       cmdByte,
    output logic                  cmdStrobe,
    output logic                  cmdAccept,
    output logic                  globalReq,
    output logic      [3:0]       globalBits,
    output logic                  protectionLockBit,
    output logic                  writeEnableLatch,
    output logic                  programErrorFlag,
    output logic      [7:0]       deviceStatus
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation and edge finding

    logic [3:0] pinSync;      // {wpN, si, sck, csN} after two flops
    logic       csSync;       // chip select, high = deselected
    logic       sckSync;      // serial clock level
    logic       siSync;       // serial data in
    logic       protectPinLevel; // 1 = protect pin deasserted
    logic       sckPrev_ff;   // last sampled clock level
    logic       csPrev_ff;    // last sampled select level
    logic       sckRise;      // host data valid, sample here
    logic       sckFall;      // launch next output bit here
    logic       csEnd;        // select just went high

    fsr_pin_sync #(
        .W       (4)
    ) u_sync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .ce      (ce),
        .pinIn   ({wpN, si, sck, csN}),
        .pinSync (pinSync)
    );

    assign csSync          = pinSync[0];
    assign sckSync         = pinSync[1];
    assign siSync          = pinSync[2];
    assign protectPinLevel = pinSync[3];

    // edges count only while selected, so a clock parked high
    // (mode 3) between frames adds no bit
    assign sckRise = ce & ~csSync & sckSync & ~sckPrev_ff;
    assign sckFall = ce & ~csSync & ~sckSync & sckPrev_ff;
    assign csEnd   = ce & csSync & ~csPrev_ff;

    // previous levels for the edge detectors
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sckPrev_ff <= 1'h0;
            csPrev_ff  <= 1'h1;
        end else if (ce) begin
            sckPrev_ff <= sckSync;
            csPrev_ff  <= csSync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live status byte

    logic       lock_ff;      // protection_lock_bit
    logic       wel_ff;       // write_enable_latch
    logic       err_ff;       // program_error_flag
    logic [7:0] statusNow;    // assembled every cycle

    // rebuilt each cycle, so every bit shifted is live
    fsr_status_mux #(
        .NSECT      (NSECT)
    ) u_mux (
        .lockBit    (lock_ff),
        .errFlag    (err_ff),
        .wpLevel    (protectPinLevel),
        .sectorProt (sectorProt),
        .welBit     (wel_ff),
        .busyBit    (busy),
        .statusByte (statusNow)
    );

    ////////////////////////////////////////////////////////////////////////
    // serial sequencer state

    fsr_state_type state_ff;      // what this frame is doing
    fsr_state_type nxt_state;
    logic [2:0]    bitCnt_ff;     // bits taken in the current byte
    logic [2:0]    nxt_bitCnt;
    logic [7:0]    shift_ff;      // incoming bits
    logic [7:0]    nxt_shift;
    logic [7:0]    shiftNew;      // shift with this edge's bit
    logic [2:0]    outIdx_ff;     // next status bit to launch
    logic [2:0]    nxt_outIdx;
    logic          so_ff;         // serial output bit
    logic          nxt_so;
    logic          soOeN_ff;      // low while driving the pin
    logic          nxt_soOeN;
    logic          dataGot_ff;    // write-status data byte complete
    logic          nxt_dataGot;
    logic [7:0]    wsData_ff;     // first data byte of write-status
    logic [7:0]    nxt_wsData;
    logic [7:0]    cmdByte_ff;    // last opcode handed on
    logic [7:0]    nxt_cmdByte;
    logic          cmdStrobe_ff;  // opcode ready for the engine
    logic          nxt_cmdStrobe;

    ////////////////////////////////////////////////////////////////////////
    // status bit state

    logic       nxt_lock;
    logic       nxt_wel;
    logic       nxt_err;
    logic       globalReq_ff;     // global protect/unprotect request
    logic       nxt_globalReq;
    logic [3:0] globalBits_ff;    // its four data bits
    logic [3:0] nxt_globalBits;
    logic       wsApply;          // write-status completes this cycle
    logic       wsAbort;          // write-status aborts this cycle
    logic       wsIllegal;        // lock clear under asserted pin

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        nxt_state     = state_ff;
        nxt_bitCnt    = bitCnt_ff;
        nxt_shift     = shift_ff;
        nxt_outIdx    = outIdx_ff;
        nxt_so        = so_ff;
        nxt_soOeN     = soOeN_ff;
        nxt_dataGot   = dataGot_ff;
        nxt_wsData    = wsData_ff;
        nxt_cmdByte   = cmdByte_ff;
        nxt_cmdStrobe = 1'h0;
        shiftNew      = {shift_ff[6:0], siSync};
        if (csSync) begin
            // deselected: frame over at any bit, output released
            nxt_state   = ST_OPC;
            nxt_bitCnt  = 3'h0;
            nxt_soOeN   = 1'h1;
            nxt_dataGot = 1'h0;
        end else begin
            // input bits taken on rising clock
            if (sckRise) begin
                nxt_shift  = shiftNew;
                nxt_bitCnt = 3'(bitCnt_ff + 3'h1);
                if (bitCnt_ff == MSB_IDX) begin
                    // one full byte received
                    case (state_ff)
                        ST_OPC: begin
                            nxt_cmdByte = shiftNew;
                            if (shiftNew == OPC_READ_STATUS) begin
                                // no busy check, read always served
                                nxt_state  = ST_STAT;
                                nxt_outIdx = MSB_IDX;
                            end else if (shiftNew == OPC_WRITE_STATUS) begin
                                nxt_state  = ST_WSR;
                            end else begin
                                nxt_state     = ST_PASS;
                                nxt_cmdStrobe = 1'h1;
                            end
                        end
                        ST_WSR: begin
                            // only the first data byte counts
                            if (!dataGot_ff) begin
                                nxt_wsData  = shiftNew;
                                nxt_dataGot = 1'h1;
                            end
                        end
                        default: begin
                            nxt_state = state_ff;
                        end
                    endcase
                end
            end
            // output bits launched on falling clock, msb first
            if (sckFall && state_ff == ST_STAT) begin
                nxt_so     = statusNow[outIdx_ff];
                nxt_soOeN  = 1'h0;
                nxt_outIdx = 3'(outIdx_ff - 3'h1);
            end
        end
    end

    // sequencer registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff     <= ST_OPC;
            bitCnt_ff    <= 3'h0;
            shift_ff     <= 8'h00;
            outIdx_ff    <= MSB_IDX;
            so_ff        <= 1'h0;
            soOeN_ff     <= 1'h1;
            dataGot_ff   <= 1'h0;
            wsData_ff    <= 8'h00;
            cmdByte_ff   <= 8'h00;
            cmdStrobe_ff <= 1'h0;
        end else if (ce) begin
            state_ff     <= nxt_state;
            bitCnt_ff    <= nxt_bitCnt;
            shift_ff     <= nxt_shift;
            outIdx_ff    <= nxt_outIdx;
            so_ff        <= nxt_so;
            soOeN_ff     <= nxt_soOeN;
            dataGot_ff   <= nxt_dataGot;
            wsData_ff    <= nxt_wsData;
            cmdByte_ff   <= nxt_cmdByte;
            cmdStrobe_ff <= nxt_cmdStrobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write-status decision at deselect
    // bit count 0 here means the frame
    // ended on a byte boundary
    always_comb begin
        wsApply   = 1'h0;
        wsAbort   = 1'h0;
        wsIllegal = 1'h0;
        if (csEnd && state_ff == ST_WSR && wel_ff) begin
            if (dataGot_ff && bitCnt_ff == 3'h0) begin
                // pin asserted reads 0 on the level
                wsIllegal = ~protectPinLevel & lock_ff & ~wsData_ff[BIT_LOCK];
                wsApply   = ~wsIllegal;
            end else begin
                wsAbort = 1'h1;   // short data or bit count not a whole number of bytes
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status bits next state
    always_comb begin
        nxt_lock       = lock_ff;
        nxt_wel        = wel_ff;
        nxt_err        = err_ff;
        nxt_globalReq  = 1'h0;
        nxt_globalBits = globalBits_ff;
        // lock: only write-status moves it; reset command leaves it
        if (wsApply) begin
            nxt_lock = wsData_ff[BIT_LOCK];
            // global protection uses the lock value before this write
            if (!lock_ff) begin
                nxt_globalReq  = 1'h1;
                nxt_globalBits = wsData_ff[GP_HI:GP_LO];
            end
        end
        // latch clears first, a set in the same cycle then wins
        if (wsApply || wsAbort || wsIllegal) begin
            nxt_wel = 1'h0;
        end
        if (weClear || resetCmd) begin
            nxt_wel = 1'h0;
        end
        if (weSet) begin
            nxt_wel = 1'h1;
        end
        // error flag refreshed on completions only, aborts leave it
        if (opDone) begin
            nxt_err = opFail;
        end
    end

    // status bit registers; power-up values
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lock_ff       <= LOCK_RST;
            wel_ff        <= WEL_RST;
            err_ff        <= ERR_RST;
            globalReq_ff  <= 1'h0;
            globalBits_ff <= 4'h0;
        end else if (ce) begin
            lock_ff       <= nxt_lock;
            wel_ff        <= nxt_wel;
            err_ff        <= nxt_err;
            globalReq_ff  <= nxt_globalReq;
            globalBits_ff <= nxt_globalBits;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // only a complete opcode is strobed, so a cut one
    // never reaches the engine's latch clear
    assign cmdAccept = cmdStrobe_ff & (~cmdGated | wel_ff)
                       & ~(cmdIsProt & lock_ff);
    assign cmdByte           = cmdByte_ff;
    assign cmdStrobe         = cmdStrobe_ff;
    assign so                = so_ff;
    assign soOeN             = soOeN_ff;
    assign globalReq         = globalReq_ff;
    assign globalBits        = globalBits_ff;
    assign protectionLockBit = lock_ff;
    assign writeEnableLatch  = wel_ff;
    assign programErrorFlag  = err_ff;
    assign deviceStatus      = statusNow;

endmodule : fsr_status_logic
`default_nettype wire

//--- sim/fsr_status_logic_sva.sv
// port-level assertions of the status register block
`timescale 1ns/10ps
`default_nettype none
module fsr_status_logic_sva
    import fsr_pkg::*;
#(
    parameter int NSECT = 4
) (
    input wire logic             ref_clk,
    input wire logic             nrst,
    input wire logic             csN,
    input wire logic             soOeN,
    input wire logic             wpN,
    input wire logic             busy,
    input wire logic             opDone,
    input wire logic             opFail,
    input wire logic             weSet,
    input wire logic             weClear,
    input wire logic             resetCmd,
    input wire logic [NSECT-1:0] sectorProt,
    input wire logic             cmdGated,
    input wire logic             cmdIsProt,
    input wire logic             cmdStrobe,
    input wire logic             cmdAccept,
    input wire logic             globalReq,
    input wire logic             protectionLockBit,
    input wire logic             writeEnableLatch,
    input wire logic             programErrorFlag,
    input wire logic [7:0]       deviceStatus
);
    // one domain: ref_clk, quiet in reset
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////
    // status byte contents
    chk_rsvd_zero: assert property (deviceStatus[BIT_RSVD] == 1'h0)
        else $error("reserved status bit set");
    chk_bit_map: assert property (deviceStatus[BIT_LOCK] == protectionLockBit
        && deviceStatus[BIT_ERR] == programErrorFlag
        && deviceStatus[BIT_WEL] == writeEnableLatch && deviceStatus[BIT_BUSY] == busy)
        else $error("status bits differ from sources");
    chk_swp_sum: assert property (deviceStatus[3:2] == ((&sectorProt) ? SWP_ALL
        : ((|sectorProt) ? SWP_SOME : SWP_NONE)))
        else $error("protection summary wrong");
    // pin passes two sync flops; judge only levels held that long
    chk_wpp_pin: assert property ($past(nrst, 2) && $stable(wpN) && $past(wpN, 2) == wpN
        |-> deviceStatus[BIT_WPP] == wpN)
        else $error("pin status bit does not follow pin");

    ////////////////////////////////////////////////////////////////////////////
    // latch, lock and error flag events
    chk_lock_keep: assert property (resetCmd |=> $stable(protectionLockBit))
        else $error("reset command changed lock");
    chk_wel_reset: assert property (resetCmd && !weSet |=> !writeEnableLatch)
        else $error("reset command left latch set");
    chk_wel_clear: assert property (weClear && !weSet |=> !writeEnableLatch)
        else $error("latch not cleared");
    chk_err_load: assert property (opDone |=> programErrorFlag == $past(opFail))
        else $error("error flag not loaded");
    chk_err_hold: assert property (!opDone |=> $stable(programErrorFlag))
        else $error("error flag moved without op end");
    chk_accept_gate: assert property (cmdAccept == (cmdStrobe
        && (!cmdGated || writeEnableLatch) && !(cmdIsProt && protectionLockBit)))
        else $error("command acceptance wrong");
    // lock one edge back is the old value
    chk_global_lock: assert property (globalReq |-> !$past(protectionLockBit))
        else $error("global request while locked");
    chk_cs_release: assert property (csN [*6] |-> soOeN)
        else $error("output still enabled after deselect");

    ////////////////////////////////////////////////////////////////////////////
    // main scenarios reached
    cov_global: cover property (globalReq);
    cov_err: cover property (opDone && opFail);
    cov_busy_read: cover property (!soOeN && busy);
endmodule : fsr_status_logic_sva

bind fsr_status_logic fsr_status_logic_sva #(.NSECT(NSECT)) u_fsr_status_logic_sva (
    .ref_clk(ref_clk), .nrst(nrst), .csN(csN), .soOeN(soOeN), .wpN(wpN), .busy(busy),
    .opDone(opDone), .opFail(opFail), .weSet(weSet), .weClear(weClear),
    .resetCmd(resetCmd), .sectorProt(sectorProt), .cmdGated(cmdGated),
    .cmdIsProt(cmdIsProt), .cmdStrobe(cmdStrobe), .cmdAccept(cmdAccept),
    .globalReq(globalReq), .protectionLockBit(protectionLockBit),
    .writeEnableLatch(writeEnableLatch), .programErrorFlag(programErrorFlag),
    .deviceStatus(deviceStatus)
);
`default_nettype wire

//--- sim/fsr_spi_host.sv
// behavioural serial host: mode 0, clock still between frames
`timescale 1ns/10ps
`default_nettype none
module fsr_spi_host (
    input  wire logic ref_clk,
    input  wire logic so,
    input  wire logic soOeN,
    output var logic  csN,
    output var logic  sck,
    output var logic  si
);
    // released output floats, a missing drive reads z
    wire logic soLine = soOeN ? 1'hz : so;

    initial begin
        csN = 1'h1;
        sck = 1'h0;
        si  = 1'h0;
    end

    task automatic waitn(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : waitn

    task automatic sel();
        waitn(1);
        csN = 1'h0;
        waitn(4);
    endtask : sel

    // deselect at any bit; data line flips once undriven
    task automatic desel();
        waitn(4);
        csN = 1'h1;
        si  = ~si;
        waitn(8);
    endtask : desel

    // n bits msb first, half period of four system clocks
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            si = tx[i];
            waitn(4);
            sck = 1'h1;
            waitn(4);
            rx[i] = soLine;
            sck = 1'h0;
        end
    endtask : xfer
endmodule : fsr_spi_host
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the status register block
`timescale 1ns/10ps
`default_nettype none
module tb
    import fsr_pkg::*;
;
    logic       ref_clk, nrst, wpN, busy, opDone, opFail, weSet, weClear, resetCmd;
    logic       csN, sck, si, so, soOeN, cmdGated, cmdIsProt, cmdStrobe, cmdAccept;
    logic       globalReq, lastAcc, lockM, errM, welM;
    logic [3:0] sectorProt, globalBits;
    logic [7:0] cmdByte, deviceStatus, lastByte;
    int         errCount = 0, samplesChecked = 0, gCnt = 0;

    fsr_status_logic u_fsr_status_logic (
        .ref_clk(ref_clk), .nrst(nrst), .ce(1'h1), .csN(csN), .sck(sck), .si(si),
        .so(so), .soOeN(soOeN), .wpN(wpN), .busy(busy), .opDone(opDone), .opFail(opFail),
        .weSet(weSet), .weClear(weClear), .resetCmd(resetCmd), .sectorProt(sectorProt),
        .cmdGated(cmdGated), .cmdIsProt(cmdIsProt), .cmdByte(cmdByte),
        .cmdStrobe(cmdStrobe), .cmdAccept(cmdAccept), .globalReq(globalReq),
        .globalBits(globalBits), .protectionLockBit(), .writeEnableLatch(),
        .programErrorFlag(), .deviceStatus(deviceStatus)
    );
    fsr_spi_host u_fsr_spi_host (
        .ref_clk(ref_clk), .so(so), .soOeN(soOeN), .csN(csN), .sck(sck), .si(si)
    );

    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // last decoded opcode, global request count
    always @(posedge ref_clk) begin
        if (cmdStrobe === 1'h1) begin
            lastByte <= cmdByte;
            lastAcc  <= cmdAccept;
        end
        gCnt <= gCnt + int'(globalReq === 1'h1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [7:0] expStat();
        return {lockM, 1'h0, errM, wpN,
                (&sectorProt) ? SWP_ALL : ((|sectorProt) ? SWP_SOME : SWP_NONE), welM, busy};
    endfunction : expStat

    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        samplesChecked++;
        if (act !== exp) begin
            errCount++;
            $display("ERROR t=%0t got %h exp %h", $time, act, exp);
        end
    endtask : chk

    task automatic pulse(input logic [3:0] e);
        {opDone, weSet, weClear, resetCmd} = e;
        @(negedge ref_clk);
        {opDone, weSet, weClear, resetCmd} = 4'h0;
        @(negedge ref_clk);
        welM = welM | e[2];
    endtask : pulse

    // one frame of up to three bytes, bit counts per byte
    task automatic frame(input logic [7:0] a, b, c, input int na, nb, nc);
        logic [7:0] d;
        u_fsr_spi_host.sel();
        u_fsr_spi_host.xfer(a, na, d);
        u_fsr_spi_host.xfer(b, nb, d);
        u_fsr_spi_host.xfer(c, nc, d);
        u_fsr_spi_host.desel();
    endtask : frame

    // enable, then write-status
    task automatic wsr(input logic [7:0] d, input int nb, nc);
        pulse(4'h4);
        frame(OPC_WRITE_STATUS, d, 8'h00, 8, nb, nc);
    endtask : wsr

    task automatic rdChk();
        logic [7:0] v;
        u_fsr_spi_host.sel();
        u_fsr_spi_host.xfer(OPC_READ_STATUS, 8, v);
        u_fsr_spi_host.xfer(8'h00, 8, v);
        u_fsr_spi_host.desel();
        chk(v, expStat());
    endtask : rdChk

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic s_stream();
        logic [7:0] v;
        busy = 1'h1;
        u_fsr_spi_host.sel();
        u_fsr_spi_host.xfer(OPC_READ_STATUS, 8, v);
        u_fsr_spi_host.xfer(8'h00, 8, v);
        chk(v, expStat());
        {busy, wpN, sectorProt} = 6'h00;
        u_fsr_spi_host.xfer(8'h00, 8, v);
        chk(v, expStat());
        sectorProt = 4'h3;
        u_fsr_spi_host.xfer(8'h00, 8, v);
        chk(v, expStat());
        u_fsr_spi_host.xfer(8'h00, 3, v);
        u_fsr_spi_host.desel();
        chk(v & 8'he0, expStat() & 8'he0);
        chk({7'h0, soOeN}, 8'h01);
        {wpN, sectorProt} = 5'h1f;
    endtask : s_stream

    task automatic s_write();
        frame(OPC_WRITE_STATUS, 8'hbc, 8'h00, 8, 8, 0);
        rdChk();
        wsr(8'hbc, 8, 0);
        {lockM, welM} = 2'h2;
        rdChk();
        chk({gCnt[3:0], globalBits}, 8'h1f);
        wpN = 1'h0;
        wsr(8'h00, 8, 0);
        welM = 1'h0;
        rdChk();
        wpN = 1'h1;
        wsr(8'h00, 8, 0);
        {lockM, welM} = 2'h0;
        rdChk();
        chk({4'h0, gCnt[3:0]}, 8'h01);
        wsr(8'h80, 4, 0);
        welM = 1'h0;
        rdChk();
        wpN = 1'h0;
        wsr(8'h80, 8, 8);
        {lockM, welM} = 2'h2;
        rdChk();
        wpN = 1'h1;
    endtask : s_write

    task automatic s_engine();
        opFail = 1'h1;
        pulse(4'h8);
        errM = 1'h1;
        chk(deviceStatus, expStat());
        opFail = 1'h0;
        pulse(4'h8);
        opFail = 1'h1;
        errM = 1'h0;
        chk(deviceStatus, expStat());
        pulse(4'h4);
        pulse(4'h2);
        welM = 1'h0;
        chk(deviceStatus, expStat());
        pulse(4'h4);
        pulse(4'h1);
        welM = 1'h0;
        chk(deviceStatus, expStat());
    endtask : s_engine

    task automatic s_command();
        {cmdGated, cmdIsProt} = 2'h2;
        frame(8'h20, 8'h00, 8'h00, 8, 0, 0);
        chk({lastAcc, lastByte[6:0]}, 8'h20);
        pulse(4'h4);
        cmdIsProt = 1'h1;
        frame(8'h36, 8'h00, 8'h00, 8, 0, 0);
        chk({lastAcc, lastByte[6:0]}, 8'h36);
        cmdIsProt = 1'h0;
        frame(8'h20, 8'h00, 8'h00, 8, 0, 0);
        chk({lastAcc, lastByte[6:0]}, 8'ha0);
        frame(8'h36, 8'h00, 8'h00, 4, 0, 0);
        chk(lastByte, 8'h20);
        chk(deviceStatus, expStat());
    endtask : s_command

    task automatic conclude();
        $display("checks %0d errors %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        {nrst, opDone, opFail, weSet, weClear, resetCmd, cmdGated, cmdIsProt} = 8'h00;
        {wpN, busy, sectorProt} = 6'h2f;
        {lockM, errM, welM} = 3'h0;
        repeat (20) @(negedge ref_clk);
        nrst = 1'h1;
        u_fsr_spi_host.waitn(4);
        chk(deviceStatus, expStat());
        s_stream();
        s_write();
        s_engine();
        s_command();
        conclude();
    end

    initial begin
        #500us;
        errCount++;
        $display("ERROR t=%0t timeout got %h exp %h", $time, 1'h0, 1'h1);
        conclude();
    end
endmodule : tb
`default_nettype wire
